// file: include/afsg_defines.svh
// register map, field positions, reset values and timing counts of the frame-sync block
// Notes on behaviour
// - primary controller makes frame sync from internal bit clock when bit 7 set.
// - primary bit 6 inverts bit-clock polarity only for frame-sync generation.
// - primary ratio is 6-bit upper field joined with 8-bit lower byte.
// - secondary controller makes frame sync from internal bit clock when bit 7 set.
// - secondary bit 6 inverts bit-clock polarity only for its frame sync.
// - secondary ratio is 6-bit upper field joined with following lower byte.
// - status bit 7 shows a frame-sync to bit-clock ratio error on either port.
// - status bit 4 shows unsupported rate-converter ratio, masked under custom ratio.
// - status bit 3 shows a clock setup that gives no valid matching rate.
// - status bit 2 shows a clock setup that gives no valid density clock.
// - status bit 1 shows audio clock stopped for at least one millisecond.
// - reserved bits read zero; writes leave only the reset value there.
// - a port generates frame sync only while its controller select is one.
`ifndef AFSG_DEFINES_SVH
`define AFSG_DEFINES_SVH

// ==========================================================
// register offsets
`define AFSG_ADDR_PRI_CTRL 8'h38
`define AFSG_ADDR_PRI_LOW 8'h39
`define AFSG_ADDR_SEC_CTRL 8'h3A
`define AFSG_ADDR_SEC_LOW 8'h3B
`define AFSG_ADDR_STATUS 8'h3C

// ==========================================================
// field positions
`define AFSG_BIT_USE_INT 7
`define AFSG_BIT_INVERT 6
`define AFSG_UPPER_MSB 5
`define AFSG_STS_RATIO 7
`define AFSG_STS_SRC 4
`define AFSG_STS_DEM 3
`define AFSG_STS_PDM 2
`define AFSG_STS_STOP 1

// ==========================================================
// reset values
`define AFSG_CTRL_RST 8'h00
`define AFSG_LOW_RST 8'h00
`define AFSG_STS_RST 8'h00
`define AFSG_UNMAPPED_RD 8'h00

// ==========================================================
// timing
`define AFSG_CLK_STOP_US 1000
`define AFSG_MCLK_KHZ 25000
`define AFSG_STOP_CYCLES ((`AFSG_CLK_STOP_US * `AFSG_MCLK_KHZ + 999) / 1000)
`define AFSG_INT_BCLK_HALF 2

`endif

// file: include/afsg_pkg.sv
// types shared by the frame-sync generator and its control top
package afsg_pkg;

  // bit clocks per frame
  typedef logic [13:0] afsg_ratio_t;

  // per-port generation settings
  typedef struct packed {
    logic controller;
    logic use_int;
    logic invert;
    afsg_ratio_t ratio;
  } afsg_cfg_s;

endpackage : afsg_pkg

// file: include/afsg_port_if.sv
// settings and pin views passed between the top and one port generator
`timescale 1ns/1ps
interface afsg_port_if;
  import afsg_pkg::*;
  afsg_cfg_s cfg;
  logic int_bclk;
  logic ext_bclk;
  logic ext_fsync;
  logic fsync;
  logic fsync_oe;
  logic ratio_err;
  modport gen (input cfg, input int_bclk, input ext_bclk, input ext_fsync,
               output fsync, output fsync_oe, output ratio_err);
  modport ctl (output cfg, output int_bclk, output ext_bclk, output ext_fsync,
               input fsync, input fsync_oe, input ratio_err);
endinterface : afsg_port_if

// file: hdl/afsg_fsync_gen.sv
// one serial port: frame-sync generation in controller mode, ratio check in target mode
`timescale 1ns/1ps
module afsg_fsync_gen (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // port settings and pins
  afsg_port_if.gen port
);
  import afsg_pkg::*;

  logic gen_clk;
  logic gen_prev_r;
  logic gen_edge;
  logic bclk_prev_r;
  logic bclk_rise;
  logic fs_prev_r;
  logic fs_rise;
  logic run;
  afsg_ratio_t gen_cnt_r;
  afsg_ratio_t chk_cnt_r;
  logic armed_r;
  logic fsync_r;
  logic err_r;

  // ==========================================================
  // clock selection
  // inversion touches only the copy used to time the frame
  assign gen_clk = (port.cfg.use_int ? port.int_bclk : port.ext_bclk) ^ port.cfg.invert;
  assign gen_edge = gen_clk & ~gen_prev_r;
  assign bclk_rise = port.ext_bclk & ~bclk_prev_r;
  assign fs_rise = port.ext_fsync & ~fs_prev_r;
  assign run = port.cfg.controller && (port.cfg.ratio != 14'h0000);

  // edge history
  always_ff @(posedge mclk) begin
    if (rst) begin
      gen_prev_r <= 1'b0;
      bclk_prev_r <= 1'b0;
      fs_prev_r <= 1'b0;
    end else if (ce) begin
      gen_prev_r <= gen_clk;
      bclk_prev_r <= port.ext_bclk;
      fs_prev_r <= port.ext_fsync;
    end
  end

  // ==========================================================
  // frame counter: one-bit-clock-wide frame sync every ratio edges
  always_ff @(posedge mclk) begin
    if (rst) begin
      gen_cnt_r <= 14'h0000;
      fsync_r <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        gen_cnt_r <= 14'h0000;
        fsync_r <= 1'b0;
      end else if (gen_edge) begin
        if (gen_cnt_r >= port.cfg.ratio - 14'h0001) begin
          gen_cnt_r <= 14'h0000;
          fsync_r <= 1'b1;
        end else begin
          gen_cnt_r <= gen_cnt_r + 14'h0001;
          fsync_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // target-mode check of incoming frame length
  // first frame only arms, its length is unknown
  always_ff @(posedge mclk) begin
    if (rst) begin
      chk_cnt_r <= 14'h0000;
      armed_r <= 1'b0;
      err_r <= 1'b0;
    end else if (ce) begin
      if (port.cfg.controller || port.cfg.ratio == 14'h0000) begin
        chk_cnt_r <= 14'h0000;
        armed_r <= 1'b0;
        err_r <= 1'b0;
      end else if (fs_rise) begin
        chk_cnt_r <= {13'h0000, bclk_rise};
        armed_r <= 1'b1;
        err_r <= armed_r && (chk_cnt_r != port.cfg.ratio);
      end else if (bclk_rise && chk_cnt_r != 14'h3FFF) begin
        chk_cnt_r <= chk_cnt_r + 14'h0001;
      end
    end
  end

  assign port.fsync = fsync_r;
  assign port.fsync_oe = port.cfg.controller;
  assign port.ratio_err = err_r;

endmodule : afsg_fsync_gen

// file: hdl/afsg_top.sv
// frame-sync generation settings and clock-error status for both serial ports
`timescale 1ns/1ps
`include "afsg_defines.svh"
module afsg_top #(
  parameter int unsigned STOP_CYCLES = `AFSG_STOP_CYCLES,
  parameter int unsigned INT_BCLK_HALF = `AFSG_INT_BCLK_HALF
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // port roles from the clock configuration
  input wire logic pri_port_controller_sel,
  input wire logic sec_port_controller_sel,
  // fault conditions from clock planning logic
  input wire logic rate_converter_ratio_fault,
  input wire logic custom_ratio_cfg,
  input wire logic element_matching_rate_fault,
  input wire logic density_clock_fault,
  // primary serial port pins
  input wire logic pri_bclk_in,
  output logic pri_bclk_out,
  output logic pri_bclk_oe,
  input wire logic pri_fsync_in,
  output logic pri_fsync_out,
  output logic pri_fsync_oe,
  // secondary serial port pins
  input wire logic sec_bclk_in,
  output logic sec_bclk_out,
  output logic sec_bclk_oe,
  input wire logic sec_fsync_in,
  output logic sec_fsync_out,
  output logic sec_fsync_oe,
  // audio clock source
  input wire logic audio_clk_in,
  // status views
  output logic audio_clock_stopped_flag,
  output afsg_pkg::afsg_ratio_t pri_ratio,
  output afsg_pkg::afsg_ratio_t sec_ratio
);
  import afsg_pkg::*;

  localparam int STOP_W = $clog2(STOP_CYCLES + 1);
  localparam int DIV_W = $clog2(INT_BCLK_HALF + 1);

  // ==========================================================
  // parameter checks
  generate
    if (STOP_CYCLES < 2) begin : g_bad_stop
      $error("STOP_CYCLES must be at least 2");
    end
    if (INT_BCLK_HALF < 1) begin : g_bad_div
      $error("INT_BCLK_HALF must be at least 1");
    end
  endgenerate

  logic [7:0] pri_ctrl_r;
  logic [7:0] pri_low_r;
  logic [7:0] sec_ctrl_r;
  logic [7:0] sec_low_r;
  logic [7:0] sts_r;
  logic [7:0] sts_nxt;
  logic [7:0] rdata_r;
  logic [4:0] pin_raw;
  logic [4:0] pin_meta_r;
  logic [4:0] pin_sync_r;
  logic aclk_prev_r;
  logic [STOP_W-1:0] stop_cnt_r;
  logic stop_flag;
  logic [DIV_W-1:0] div_cnt_r;
  logic int_bclk_r;
  afsg_cfg_s cfg_a [2];
  logic [1:0] fsync_a;
  logic [1:0] fsync_oe_a;
  logic [1:0] err_a;
  logic [1:0] ext_bclk_a;
  logic [1:0] ext_fsync_a;

  // ==========================================================
  // pin synchronisers
  assign pin_raw = {audio_clk_in, sec_fsync_in, sec_bclk_in, pri_fsync_in, pri_bclk_in};

  // two flops per pin
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (rst) begin
          pin_meta_r[gi] <= 1'b0;
          pin_sync_r[gi] <= 1'b0;
        end else if (ce) begin
          pin_meta_r[gi] <= pin_raw[gi];
          pin_sync_r[gi] <= pin_meta_r[gi];
        end
      end
    end
  endgenerate

  assign ext_bclk_a = {pin_sync_r[2], pin_sync_r[0]};
  assign ext_fsync_a = {pin_sync_r[3], pin_sync_r[1]};

  // ==========================================================
  // internal bit clock divider
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_cnt_r <= '0;
      int_bclk_r <= 1'b0;
    end else if (ce) begin
      if (div_cnt_r == DIV_W'(INT_BCLK_HALF - 1)) begin
        div_cnt_r <= '0;
        int_bclk_r <= ~int_bclk_r;
      end else begin
        div_cnt_r <= div_cnt_r + DIV_W'(1);
      end
    end
  end

  // ==========================================================
  // writable registers, control regs have no reserved bits
  always_ff @(posedge mclk) begin
    if (rst) begin
      pri_ctrl_r <= `AFSG_CTRL_RST;
      pri_low_r <= `AFSG_LOW_RST;
      sec_ctrl_r <= `AFSG_CTRL_RST;
      sec_low_r <= `AFSG_LOW_RST;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `AFSG_ADDR_PRI_CTRL: pri_ctrl_r <= reg_wdata;
        `AFSG_ADDR_PRI_LOW: pri_low_r <= reg_wdata;
        `AFSG_ADDR_SEC_CTRL: sec_ctrl_r <= reg_wdata;
        `AFSG_ADDR_SEC_LOW: sec_low_r <= reg_wdata;
        default: ; // status and unmapped writes dropped
      endcase
    end
  end

  // ==========================================================
  // per-port settings
  assign pri_ratio = {pri_ctrl_r[`AFSG_UPPER_MSB:0], pri_low_r};
  assign sec_ratio = {sec_ctrl_r[`AFSG_UPPER_MSB:0], sec_low_r};

  always_comb begin
    cfg_a[0].controller = pri_port_controller_sel;
    cfg_a[0].use_int = pri_ctrl_r[`AFSG_BIT_USE_INT];
    cfg_a[0].invert = pri_ctrl_r[`AFSG_BIT_INVERT];
    cfg_a[0].ratio = pri_ratio;
    cfg_a[1].controller = sec_port_controller_sel;
    cfg_a[1].use_int = sec_ctrl_r[`AFSG_BIT_USE_INT];
    cfg_a[1].invert = sec_ctrl_r[`AFSG_BIT_INVERT];
    cfg_a[1].ratio = sec_ratio;
  end

  // one generator per port
  generate
    for (gi = 0; gi < 2; gi++) begin : g_port
      afsg_port_if pif ();
      assign pif.cfg = cfg_a[gi];
      assign pif.int_bclk = int_bclk_r;
      assign pif.ext_bclk = ext_bclk_a[gi];
      assign pif.ext_fsync = ext_fsync_a[gi];
      assign fsync_a[gi] = pif.fsync;
      assign fsync_oe_a[gi] = pif.fsync_oe;
      assign err_a[gi] = pif.ratio_err;
      afsg_fsync_gen u_gen (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .port(pif.gen)
      );
    end
  endgenerate

  // ==========================================================
  // pin outputs; bit clock out keeps normal polarity
  assign pri_bclk_out = int_bclk_r;
  assign pri_bclk_oe = pri_port_controller_sel & pri_ctrl_r[`AFSG_BIT_USE_INT];
  assign sec_bclk_out = int_bclk_r;
  assign sec_bclk_oe = sec_port_controller_sel & sec_ctrl_r[`AFSG_BIT_USE_INT];
  assign pri_fsync_out = fsync_a[0];
  assign pri_fsync_oe = fsync_oe_a[0];
  assign sec_fsync_out = fsync_a[1];
  assign sec_fsync_oe = fsync_oe_a[1];

  // ==========================================================
  // audio clock stop detector, any level change restarts the count
  always_ff @(posedge mclk) begin
    if (rst) begin
      aclk_prev_r <= 1'b0;
      stop_cnt_r <= '0;
    end else if (ce) begin
      aclk_prev_r <= pin_sync_r[4];
      if (pin_sync_r[4] != aclk_prev_r) begin
        stop_cnt_r <= '0;
      end else if (stop_cnt_r != STOP_W'(STOP_CYCLES)) begin
        stop_cnt_r <= stop_cnt_r + STOP_W'(1);
      end
    end
  end

  assign stop_flag = (stop_cnt_r == STOP_W'(STOP_CYCLES));
  assign audio_clock_stopped_flag = sts_r[`AFSG_STS_STOP];

  // ==========================================================
  // status register follows live conditions, reserved bits zero
  always_comb begin
    sts_nxt = `AFSG_STS_RST;
    sts_nxt[`AFSG_STS_RATIO] = |err_a;
    sts_nxt[`AFSG_STS_SRC] = rate_converter_ratio_fault & ~custom_ratio_cfg;
    sts_nxt[`AFSG_STS_DEM] = element_matching_rate_fault;
    sts_nxt[`AFSG_STS_PDM] = density_clock_fault;
    sts_nxt[`AFSG_STS_STOP] = stop_flag;
  end

  // no write path reaches the status flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      sts_r <= `AFSG_STS_RST;
    end else if (ce) begin
      sts_r <= sts_nxt;
    end
  end

  // ==========================================================
  // registered read data
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_r <= `AFSG_UNMAPPED_RD;
    end else if (ce && reg_rd) begin
      case (reg_addr)
        `AFSG_ADDR_PRI_CTRL: rdata_r <= pri_ctrl_r;
        `AFSG_ADDR_PRI_LOW: rdata_r <= pri_low_r;
        `AFSG_ADDR_SEC_CTRL: rdata_r <= sec_ctrl_r;
        `AFSG_ADDR_SEC_LOW: rdata_r <= sec_low_r;
        `AFSG_ADDR_STATUS: rdata_r <= sts_r;
        default: rdata_r <= `AFSG_UNMAPPED_RD;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

endmodule : afsg_top

// file: verification/afsg_chk.sv
// concurrent checks on the ports of the frame-sync block
`timescale 1ns/1ps
module afsg_chk #(
  parameter int unsigned STOP_CYCLES = 50
) (
  // watched ports
  input wire logic mclk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic pri_port_controller_sel,
  input wire logic sec_port_controller_sel,
  input wire logic rate_converter_ratio_fault,
  input wire logic custom_ratio_cfg,
  input wire logic element_matching_rate_fault,
  input wire logic density_clock_fault,
  input wire logic pri_bclk_oe,
  input wire logic pri_fsync_out,
  input wire logic pri_fsync_oe,
  input wire logic sec_fsync_oe,
  input wire logic audio_clk_in,
  input wire logic audio_clock_stopped_flag
);
  logic [15:0] still_r;
  logic aclk_d_r;
  // cycles since the raw audio clock last moved
  always_ff @(posedge mclk) begin
    aclk_d_r <= audio_clk_in;
    if (rst || audio_clk_in != aclk_d_r) begin
      still_r <= 16'h0000;
    end else if (still_r != 16'hFFFF) begin
      still_r <= still_r + 16'h0001;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_fs_oe_role: assert property ((pri_fsync_oe == pri_port_controller_sel) &&
    (sec_fsync_oe == sec_port_controller_sel)) else $error("fsync enable differs from role");
  a_target_quiet: assert property ((!pri_port_controller_sel)[*4] |-> !pri_fsync_out)
    else $error("fsync driven in target role");
  a_bclk_oe_role: assert property (pri_bclk_oe |-> pri_port_controller_sel)
    else $error("bit clock driven in target role");
  a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h38 || reg_addr > 8'h3C)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_sts_rsvd: assert property (reg_rd && reg_addr == 8'h3C
    |=> reg_rdata[6:5] == 2'b00 && !reg_rdata[0]) else $error("reserved status bits set");
  a_src_mask: assert property (reg_rd && reg_addr == 8'h3C |=> reg_rdata[4] ==
    ($past(rate_converter_ratio_fault, 2) && !$past(custom_ratio_cfg, 2)))
    else $error("rate converter flag wrong");
  a_dem_pdm: assert property (reg_rd && reg_addr == 8'h3C |=> reg_rdata[3:2] ==
    {$past(element_matching_rate_fault, 2), $past(density_clock_fault, 2)})
    else $error("matching or density flag wrong");
  a_stop_early: assert property ($rose(audio_clock_stopped_flag) |-> still_r >= STOP_CYCLES)
    else $error("stop flag set too early");
  a_stop_late: assert property (still_r == STOP_CYCLES + 8 |-> audio_clock_stopped_flag)
    else $error("stop flag not set");
  a_stop_clear: assert property ($changed(audio_clk_in) |-> ##[1:8] !audio_clock_stopped_flag)
    else $error("stop flag not cleared");
  c_fsync: cover property ($rose(pri_fsync_out));
  c_stop: cover property ($rose(audio_clock_stopped_flag));
  c_src: cover property (reg_rd && reg_addr == 8'h3C && rate_converter_ratio_fault);
endmodule : afsg_chk

// file: verification/afsg_host_model.sv
// host side of one serial port: bit clock and frame sync for target mode
`timescale 1ns/1ps
module afsg_host_model (
  // frame settings
  input wire logic en,
  input wire logic [13:0] n,
  // port pins
  output logic bclk,
  output logic fsync
);
  int cnt;
  // 320 ns bit clock, frame sync moved on falling edges; still while disabled
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
    cnt = 0;
    #7;
    forever begin
      #160;
      if (en) begin
        bclk = ~bclk;
        if (!bclk) begin
          fsync = (cnt == 0);
          cnt = (cnt + 1 >= n) ? 0 : cnt + 1;
        end
      end else begin
        bclk = 1'b0;
        fsync = 1'b0;
        cnt = 0;
      end
    end
  end
endmodule : afsg_host_model

// file: verification/tb_top.sv
// self-checking bench for the frame-sync block
`timescale 1ns/1ps
module tb_top;
  import afsg_pkg::*;
  localparam int unsigned STOPC = 50;
  localparam int unsigned HALF = 2;
  logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] sel = 2'b00, hen = 2'b00, hb, hf, bo, boe, fo, foe, bin, fin;
  logic [3:0] flt = 4'h0;
  logic aclk = 1'b0, arun = 1'b1, stopf, ce = 1'b1, blv;
  logic [1:0][13:0] hn = '0;
  afsg_ratio_t pr, sr;
  logic [7:0] expq [$];
  int fails = 0, tests_run = 0, cyc = 0;

  // ==========================================================
  // pins, design and host models
  assign bin = (boe & bo) | (~boe & hb);
  assign fin = (foe & fo) | (~foe & hf);
  afsg_top #(.STOP_CYCLES(STOPC), .INT_BCLK_HALF(HALF)) afsg_top_inst (
    .mclk, .rst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .pri_port_controller_sel(sel[0]), .sec_port_controller_sel(sel[1]),
    .rate_converter_ratio_fault(flt[3]), .custom_ratio_cfg(flt[2]),
    .element_matching_rate_fault(flt[1]), .density_clock_fault(flt[0]),
    .pri_bclk_in(bin[0]), .pri_bclk_out(bo[0]), .pri_bclk_oe(boe[0]),
    .pri_fsync_in(fin[0]), .pri_fsync_out(fo[0]), .pri_fsync_oe(foe[0]),
    .sec_bclk_in(bin[1]), .sec_bclk_out(bo[1]), .sec_bclk_oe(boe[1]),
    .sec_fsync_in(fin[1]), .sec_fsync_out(fo[1]), .sec_fsync_oe(foe[1]),
    .audio_clk_in(aclk), .audio_clock_stopped_flag(stopf), .pri_ratio(pr), .sec_ratio(sr));
  afsg_host_model afsg_host_model_inst [1:0] (.en(hen), .n(hn), .bclk(hb), .fsync(hf));

  // ==========================================================
  // clock, audio clock, timeout, read monitor
  always #20 mclk = ~mclk;
  always @(negedge mclk) begin
    if (arun && cyc % 3 == 0) aclk <= ~aclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rd_d <= reg_rd;
    if (rd_d) chk("reg_rdata", 16'(expq.pop_front()), 16'(reg_rdata));
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    expq.push_back(e);
    @(negedge mclk);
    reg_rd = 1'b0;
  endtask : rd
  function automatic logic [7:0] sts(input logic e, input logic s);
    return {e, 2'b00, flt[3] & ~flt[2], flt[1], flt[0], s, 1'b0};
  endfunction : sts
  // cycles between two frame-sync rises of port p
  task automatic period(input int p, input int e);
    int n, t0;
    logic q;
    n = 0;
    t0 = -1;
    q = 1'b1;
    while (n < 3000) begin
      @(negedge mclk);
      n++;
      if (fo[p] === 1'b1 && q === 1'b0) begin
        if (t0 >= 0) begin
          blv = bo[p];
          break;
        end
        t0 = n;
      end
      q = fo[p];
    end
    chk("fsync_period", 16'(e), 16'(n - t0));
  endtask : period
  task results;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] d, l;
    int r;
    void'($urandom(32'h4863));
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    for (int a = 8'h38; a <= 8'h3C; a++) rd(8'(a), 8'h00);
    // frozen clock enable drops a write
    ce = 1'b0;
    wr(8'h3B, 8'h5A);
    ce = 1'b1;
    rd(8'h3B, 8'h00);
    for (int p = 0; p < 2; p++) begin
      d = 8'($urandom);
      l = 8'($urandom);
      wr(8'(8'h38 + 2 * p), d);
      wr(8'(8'h39 + 2 * p), l);
      rd(8'(8'h38 + 2 * p), d);
      rd(8'(8'h39 + 2 * p), l);
      chk("ratio", {2'b00, d[5:0], l}, {2'b00, p ? sr : pr});
    end
    wr(8'h3C, 8'h9E);
    wr(8'h55, 8'hFF);
    rd(8'h3C, 8'h00);
    rd(8'h55, 8'h00);
    for (int i = 0; i < 16; i++) begin
      flt = 4'(i);
      repeat (2) @(negedge mclk);
      rd(8'h3C, sts(1'b0, 1'b0));
    end
    flt = 4'h0;
    arun = 1'b0;
    repeat (STOPC - 4) @(negedge mclk);
    chk("stop_flag", 16'h0000, {15'h0, stopf});
    repeat (24) @(negedge mclk);
    chk("stop_flag", 16'h0001, {15'h0, stopf});
    rd(8'h3C, sts(1'b0, 1'b1));
    arun = 1'b1;
    repeat (12) @(negedge mclk);
    rd(8'h3C, sts(1'b0, 1'b0));
    for (int p = 0; p < 2; p++) begin
      wr(8'(8'h38 + 2 * p), 8'h00);
      wr(8'(8'h39 + 2 * p), 8'h08);
      hn[p] = 14'd8;
      hen[p] = 1'b1;
      repeat (300) @(negedge mclk);
      rd(8'h3C, sts(1'b0, 1'b0));
      hn[p] = 14'd9;
      repeat (300) @(negedge mclk);
      rd(8'h3C, sts(1'b1, 1'b0));
      hn[p] = 14'd8;
      repeat (300) @(negedge mclk);
      rd(8'h3C, sts(1'b0, 1'b0));
      hen[p] = 1'b0;
    end
    for (int p = 0; p < 2; p++) begin
      r = 3 + int'($urandom % 6);
      sel[p] = 1'b1;
      wr(8'(8'h38 + 2 * p), 8'h80);
      wr(8'(8'h39 + 2 * p), 8'(r));
      period(p, 2 * HALF * r);
      chk("bclk_out_level", 16'h0001, {15'h0, blv});
      chk("bclk_oe", 16'h0001, {15'h0, boe[p]});
      wr(8'(8'h38 + 2 * p), 8'hC0);
      period(p, 2 * HALF * r);
      chk("bclk_out_level", 16'h0000, {15'h0, blv});
      wr(8'(8'h38 + 2 * p), 8'h00);
      hn[p] = 14'(r);
      hen[p] = 1'b1;
      period(p, 8 * r);
      sel[p] = 1'b0;
      hen[p] = 1'b0;
      repeat (10) @(negedge mclk);
      chk("fsync_idle", 16'h0000, {15'h0, fo[p]});
    end
    repeat (4) @(negedge mclk);
    results();
  end
endmodule : tb_top

bind afsg_top afsg_chk #(.STOP_CYCLES(STOP_CYCLES)) afsg_chk_inst (
  .mclk, .rst, .reg_rd, .reg_addr, .reg_rdata, .pri_port_controller_sel,
  .sec_port_controller_sel, .rate_converter_ratio_fault, .custom_ratio_cfg,
  .element_matching_rate_fault, .density_clock_fault, .pri_bclk_oe, .pri_fsync_out,
  .pri_fsync_oe, .sec_fsync_oe, .audio_clk_in, .audio_clock_stopped_flag);
